// file: rtl/mrd_datapath.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module mrd_datapath (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_i,
  // register port
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [11:0]          reg_wdata_i,
  input  wire logic                 reg_write_i,
  input  wire logic                 reg_read_i,
  output logic      [11:0]          reg_rdata_o,
  // console (pins)
  input  wire logic [11:0]          switch_pins_i,
  input  wire logic                 address_load_key_i,
  input  wire logic                 store_key_i,
  input  wire logic                 inspect_key_i,
  // control
  input  wire logic                 fetch_i,
  input  wire logic                 add_i,
  // peripheral side
  input  wire logic [11:0]          io_data_i,
  input  wire logic                 io_load_i,
  input  wire logic                 break_load_i,
  output logic      [11:0]          periph_word_o,
  // memory side
  output mrd_pkg::mrd_mem_req_s     mem_o,
  input  wire logic                 mem_done_i,
  input  wire logic [11:0]          mem_rdata_i,
  // timing and opcode decode
  output logic      [3:0]           time_state_o,
  output logic                      time_pulse_o,
  output logic      [7:0]           opcode_level_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [11:0]                 working_word;
  logic                        carry_extension;
  logic [11:0]                 instruction_pointer;
  logic [11:0]                 memory_address_latch;
  logic [11:0]                 write_buffer_word;
  logic [11:0]                 read_holding_word;
  logic [2:0]                  opcode_holder;
  logic [11:0]                 console_switch_word;
  logic [11:0]                 switch_meta;
  logic [2:0]                  key_meta;
  logic [2:0]                  key_sync;
  logic [2:0]                  key_prev;
  logic [2:0]                  key_rise;
  mrd_pkg::mrd_xfer_s          xfer_pend;
  logic                        xfer_valid;
  mrd_pkg::mrd_tstate_e        tstate;
  logic [3:0]                  sub_count;
  logic                        tpulse;
  logic                        mem_wait;
  logic                        mem_req;
  logic                        mem_write;
  logic                        console_store;
  logic                        console_inspect;
  logic                        advance_addr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      switch_meta         <= mrd_pkg::WORD_ZERO;
      console_switch_word <= mrd_pkg::WORD_ZERO;
      key_meta            <= 3'h0;
      key_sync            <= 3'h0;
      key_prev            <= 3'h0;
    end else begin
      switch_meta         <= switch_pins_i;
      console_switch_word <= switch_meta;
      key_meta            <= {inspect_key_i, store_key_i, address_load_key_i};
      key_sync            <= key_meta;
      key_prev            <= key_sync;
    end
  end

  assign key_rise = key_sync & ~key_prev;

  // ----------------------------------------------------------------
  // time states
  // ----------------------------------------------------------------
  // pulse ends each state
  assign tpulse = (sub_count == mrd_pkg::STATE_LAST) && !mem_wait;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sub_count <= 4'h0;
      tstate    <= mrd_pkg::MRD_TS1;
    end else if (tpulse) begin
      sub_count <= 4'h0;
      unique case (tstate)
        mrd_pkg::MRD_TS1: tstate <= mrd_pkg::MRD_TS2;
        mrd_pkg::MRD_TS2: tstate <= mrd_pkg::MRD_TS3;
        mrd_pkg::MRD_TS3: tstate <= mrd_pkg::MRD_TS4;
        mrd_pkg::MRD_TS4: tstate <= mrd_pkg::MRD_TS1;
      endcase
    end else if (sub_count != mrd_pkg::STATE_LAST) begin
      sub_count <= sub_count + 4'h1;
    end
  end

  always_comb begin
    time_state_o = 4'h0;
    time_state_o[tstate] = 1'b1;
  end
  assign time_pulse_o = tpulse;

  // ----------------------------------------------------------------
  // memory handshake
  // ----------------------------------------------------------------
  // request raised at end of ts1, held until completion; ts2 stalls
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mem_wait        <= 1'b0;
      mem_req         <= 1'b0;
      mem_write       <= 1'b0;
      console_store   <= 1'b0;
      console_inspect <= 1'b0;
    end else begin
      if (key_rise[1]) begin
        console_store <= 1'b1;
      end
      if (key_rise[2]) begin
        console_inspect <= 1'b1;
      end
      if (mem_wait) begin
        if (mem_done_i) begin
          mem_wait        <= 1'b0;
          mem_req         <= 1'b0;
          console_store   <= key_rise[1];
          console_inspect <= key_rise[2];
        end
      end else if (tpulse && tstate == mrd_pkg::MRD_TS1
                   && (fetch_i || console_store || console_inspect)) begin
        mem_wait  <= 1'b1;
        mem_req   <= 1'b1;
        mem_write <= console_store;
      end
    end
  end

  assign advance_addr = mem_wait && mem_done_i && (console_store || console_inspect);

  assign mem_o.req   = mem_req;
  assign mem_o.write = mem_write;
  assign mem_o.addr  = memory_address_latch;
  assign mem_o.wdata = write_buffer_word;

  // ----------------------------------------------------------------
  // read holding word and opcode
  // ----------------------------------------------------------------
  // loaded from memory only
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      read_holding_word <= mrd_pkg::WORD_ZERO;
    end else if (mem_wait && mem_done_i && !mem_write) begin
      read_holding_word <= mem_rdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      opcode_holder <= 3'h0;
    end else if (fetch_i && tpulse && tstate == mrd_pkg::MRD_TS3) begin
      opcode_holder <= read_holding_word[mrd_pkg::OPC_LSB +: mrd_pkg::OPC_W];
    end
  end

  generate
    for (genvar g = 0; g < mrd_pkg::N_OPC; g++) begin : g_decode
      assign opcode_level_o[g] = (opcode_holder == 3'(g));
    end
  endgenerate

  // ----------------------------------------------------------------
  // gating network
  // ----------------------------------------------------------------
  logic [11:0] gate_src;
  logic [11:0] gate_bus;
  logic [12:0] gate_sum;
  mrd_pkg::mrd_src_e active_src;
  mrd_pkg::mrd_dst_e active_dst;
  logic active_cmp;
  logic active_inc;
  logic gate_strobe;

  // console transfers take priority over queued software transfers
  always_comb begin
    active_src  = xfer_pend.src;
    active_dst  = xfer_pend.dst;
    active_cmp  = xfer_pend.complement;
    active_inc  = xfer_pend.increment;
    gate_strobe = xfer_valid && tpulse && tstate == mrd_pkg::MRD_TS4;
    if (key_rise[0]) begin
      active_src  = mrd_pkg::MRD_SRC_SWITCH;
      active_dst  = mrd_pkg::MRD_DST_ADDR;
      active_cmp  = 1'b0;
      active_inc  = 1'b0;
      gate_strobe = 1'b1;
    end else if (key_rise[1]) begin
      active_src  = mrd_pkg::MRD_SRC_SWITCH;
      active_dst  = mrd_pkg::MRD_DST_WBUF;
      active_cmp  = 1'b0;
      active_inc  = 1'b0;
      gate_strobe = 1'b1;
    end else if (advance_addr) begin
      active_src  = mrd_pkg::MRD_SRC_ADDR;
      active_dst  = mrd_pkg::MRD_DST_ADDR;
      active_cmp  = 1'b0;
      active_inc  = 1'b1;
      gate_strobe = 1'b1;
    end else if (break_load_i) begin
      active_src  = mrd_pkg::MRD_SRC_IO;
      active_dst  = mrd_pkg::MRD_DST_WBUF;
      active_cmp  = 1'b0;
      active_inc  = 1'b0;
      gate_strobe = 1'b1;
    end else if (io_load_i) begin
      active_src  = mrd_pkg::MRD_SRC_IO;
      active_dst  = mrd_pkg::MRD_DST_WORKING;
      active_cmp  = 1'b0;
      active_inc  = 1'b0;
      gate_strobe = 1'b1;
    end
  end

  always_comb begin
    unique case (active_src)
      mrd_pkg::MRD_SRC_WORKING: gate_src = working_word;
      mrd_pkg::MRD_SRC_IPTR:    gate_src = instruction_pointer;
      mrd_pkg::MRD_SRC_ADDR:    gate_src = memory_address_latch;
      mrd_pkg::MRD_SRC_WBUF:    gate_src = write_buffer_word;
      mrd_pkg::MRD_SRC_READ:    gate_src = read_holding_word;
      mrd_pkg::MRD_SRC_SWITCH:  gate_src = console_switch_word;
      mrd_pkg::MRD_SRC_IO:      gate_src = io_data_i;
      mrd_pkg::MRD_SRC_NONE:    gate_src = mrd_pkg::WORD_ZERO;
    endcase
  end

  // one gate per bit onto common bus
  generate
    for (genvar b = 0; b < mrd_pkg::WORD_W; b++) begin : g_gate
      assign gate_bus[b] = gate_src[b] ^ active_cmp;
    end
  endgenerate

  // carry out complements the extension when adding
  assign gate_sum = add_i ? ({1'b0, gate_bus} + {1'b0, working_word}
                             + {12'h000, active_inc})
                          : ({1'b0, gate_bus} + {12'h000, active_inc});

  // ----------------------------------------------------------------
  // destination registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      working_word    <= mrd_pkg::WORD_ZERO;
      carry_extension <= 1'b0;
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_WORKING) begin
      working_word <= reg_wdata_i;
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_CARRY) begin
      carry_extension <= reg_wdata_i[0];
    end else if (gate_strobe && active_dst == mrd_pkg::MRD_DST_WORKING) begin
      working_word <= gate_sum[11:0];
      if (add_i) begin
        carry_extension <= carry_extension ^ gate_sum[12];
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      instruction_pointer <= mrd_pkg::WORD_ZERO;
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_IPTR) begin
      instruction_pointer <= reg_wdata_i;
    end else if (gate_strobe && active_dst == mrd_pkg::MRD_DST_IPTR) begin
      instruction_pointer <= gate_sum[11:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      memory_address_latch <= mrd_pkg::WORD_ZERO;
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_ADDR) begin
      memory_address_latch <= reg_wdata_i;
    end else if (gate_strobe && active_dst == mrd_pkg::MRD_DST_ADDR) begin
      memory_address_latch <= gate_sum[11:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      write_buffer_word <= mrd_pkg::WORD_ZERO;
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_WBUF) begin
      write_buffer_word <= reg_wdata_i;
    end else if (gate_strobe && active_dst == mrd_pkg::MRD_DST_WBUF) begin
      write_buffer_word <= gate_sum[11:0];
    end
  end

  assign periph_word_o = write_buffer_word;

  // ----------------------------------------------------------------
  // queued software transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      xfer_valid <= 1'b0;
      xfer_pend  <= '{1'b0, 1'b0, mrd_pkg::MRD_SRC_NONE, mrd_pkg::MRD_DST_NONE};
    end else if (reg_write_i && reg_addr_i == mrd_pkg::REG_XFER) begin
      xfer_valid           <= 1'b1;
      xfer_pend.src        <= mrd_pkg::mrd_src_e'(reg_wdata_i[mrd_pkg::XF_SRC_LSB +: 3]);
      xfer_pend.dst        <= mrd_pkg::mrd_dst_e'(reg_wdata_i[mrd_pkg::XF_DST_LSB +: 3]);
      xfer_pend.complement <= reg_wdata_i[mrd_pkg::XF_CMP_BIT];
      xfer_pend.increment  <= reg_wdata_i[mrd_pkg::XF_INC_BIT];
    end else if (xfer_valid && tpulse && tstate == mrd_pkg::MRD_TS4) begin
      // overridden by console in that cycle: transfer dropped
      xfer_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= mrd_pkg::WORD_ZERO;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        mrd_pkg::REG_WORKING: reg_rdata_o <= working_word;
        mrd_pkg::REG_CARRY:   reg_rdata_o <= {11'h000, carry_extension};
        mrd_pkg::REG_IPTR:    reg_rdata_o <= instruction_pointer;
        mrd_pkg::REG_ADDR:    reg_rdata_o <= memory_address_latch;
        mrd_pkg::REG_WBUF:    reg_rdata_o <= write_buffer_word;
        mrd_pkg::REG_READ:    reg_rdata_o <= read_holding_word;
        mrd_pkg::REG_OPCODE:  reg_rdata_o <= {9'h000, opcode_holder};
        mrd_pkg::REG_SWITCH:  reg_rdata_o <= console_switch_word;
        mrd_pkg::REG_STATUS:  reg_rdata_o <= {7'h00, xfer_valid, mem_wait, tstate, tpulse};
        mrd_pkg::REG_DECODE:  reg_rdata_o <= {4'h0, opcode_level_o};
        default:              reg_rdata_o <= mrd_pkg::WORD_ZERO;
      endcase
    end else begin
      reg_rdata_o <= mrd_pkg::WORD_ZERO;
    end
  end

endmodule : mrd_datapath

`default_nettype wire

// file: rtl/mrd_pkg.sv
package mrd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 12;
  localparam int unsigned OPC_W    = 3;
  localparam int unsigned OPC_LSB  = 9;
  localparam int unsigned N_OPC    = 8;
  localparam int unsigned ADDR_W   = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned CYCLE_NS    = 1600;
  localparam int unsigned CYCLE_CLKS  = CYCLE_NS / CLK_NS;
  localparam int unsigned STATE_CLKS  = CYCLE_CLKS / 4;
  localparam logic [3:0]  STATE_LAST  = 4'(STATE_CLKS - 1);

  // ----------------------------------------------------------------
  // register port map (word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_WORKING   = 4'h0;
  localparam logic [3:0] REG_CARRY     = 4'h1;
  localparam logic [3:0] REG_IPTR      = 4'h2;
  localparam logic [3:0] REG_ADDR      = 4'h3;
  localparam logic [3:0] REG_WBUF      = 4'h4;
  localparam logic [3:0] REG_READ      = 4'h5;
  localparam logic [3:0] REG_OPCODE    = 4'h6;
  localparam logic [3:0] REG_SWITCH    = 4'h7;
  localparam logic [3:0] REG_XFER      = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam logic [3:0] REG_DECODE    = 4'ha;

  // transfer command fields in REG_XFER write data
  localparam int unsigned XF_SRC_LSB = 0;
  localparam int unsigned XF_DST_LSB = 3;
  localparam int unsigned XF_CMP_BIT = 6;
  localparam int unsigned XF_INC_BIT = 7;

  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONE  = 12'h001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MRD_TS1 = 2'b00,
    MRD_TS2 = 2'b01,
    MRD_TS3 = 2'b10,
    MRD_TS4 = 2'b11
  } mrd_tstate_e;

  typedef enum logic [2:0] {
    MRD_SRC_WORKING = 3'b000,
    MRD_SRC_IPTR    = 3'b001,
    MRD_SRC_ADDR    = 3'b010,
    MRD_SRC_WBUF    = 3'b011,
    MRD_SRC_READ    = 3'b100,
    MRD_SRC_SWITCH  = 3'b101,
    MRD_SRC_IO      = 3'b110,
    MRD_SRC_NONE    = 3'b111
  } mrd_src_e;

  typedef enum logic [2:0] {
    MRD_DST_WORKING = 3'b000,
    MRD_DST_IPTR    = 3'b001,
    MRD_DST_ADDR    = 3'b010,
    MRD_DST_WBUF    = 3'b011,
    MRD_DST_NONE    = 3'b111
  } mrd_dst_e;

  typedef struct packed {
    logic        complement;
    logic        increment;
    mrd_src_e    src;
    mrd_dst_e    dst;
  } mrd_xfer_s;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [11:0] addr;
    logic [11:0] wdata;
  } mrd_mem_req_s;

endpackage : mrd_pkg

// file: verification/mrd_datapath_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module mrd_datapath_monitor (
  // clock and reset
  input wire logic                  clock_i,
  input wire logic                  reset_i,
  // observed ports
  input wire logic                  mem_done_i,
  input wire mrd_pkg::mrd_mem_req_s mem_o,
  input wire logic [11:0]           periph_word_o,
  input wire logic [3:0]            time_state_o,
  input wire logic                  time_pulse_o,
  input wire logic [7:0]            opcode_level_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_state_onehot: assert property ($onehot(time_state_o))
    else $error("time state not one-hot");
  a_pulse_spacing: assert property (time_pulse_o |=> !time_pulse_o [*8])
    else $error("time pulses too close");
  a_state_rotate: assert property (time_pulse_o |=>
    time_state_o == {$past(time_state_o[2:0]), $past(time_state_o[3])})
    else $error("state did not advance after pulse");
  a_state_dwell: assert property (!time_pulse_o |=> $stable(time_state_o))
    else $error("state moved without pulse");
  a_decode_onehot: assert property ($onehot(opcode_level_o))
    else $error("opcode levels not one-hot");
  a_wdata_buffer: assert property (mem_o.wdata == periph_word_o)
    else $error("memory data not from write buffer");
  a_req_holds: assert property (mem_o.req && !mem_done_i |=>
    mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata))
    else $error("memory request changed before done");
  a_req_drops: assert property (mem_o.req && mem_done_i |=> !mem_o.req)
    else $error("memory request held after done");
  a_req_start: assert property ($rose(mem_o.req) |->
    $past(time_pulse_o) && $past(time_state_o[0]))
    else $error("memory request not after first pulse");
  a_resume_bound: assert property (mem_o.req && mem_done_i |->
    ##[1:12] (time_pulse_o && time_state_o[1]))
    else $error("second pulse not resumed after done");

  c_mem_write: cover property (mem_o.req && mem_o.write && mem_done_i);
  c_mem_read: cover property (mem_o.req && !mem_o.write && mem_done_i);
  c_top_opcode: cover property (opcode_level_o[7]);
endmodule : mrd_datapath_monitor

bind mrd_datapath mrd_datapath_monitor i_mrd_datapath_monitor (
  .clock_i        (clock_i),
  .reset_i        (reset_i),
  .mem_done_i     (mem_done_i),
  .mem_o          (mem_o),
  .periph_word_o  (periph_word_o),
  .time_state_o   (time_state_o),
  .time_pulse_o   (time_pulse_o),
  .opcode_level_o (opcode_level_o)
);

`default_nettype wire

// file: verification/mrd_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mrd_datapath_tb;
  logic                  clock_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic [3:0]            reg_addr_i = 4'h0;
  logic [11:0]           reg_wdata_i = 12'h000;
  logic                  reg_write_i = 1'b0;
  logic                  reg_read_i = 1'b0;
  logic [11:0]           reg_rdata_o;
  logic [11:0]           sw = 12'h000;
  logic [2:0]            keys = 3'h0;
  logic                  fetch_i = 1'b0;
  logic                  add_i = 1'b0;
  logic [11:0]           io_data_i = 12'h000;
  logic                  io_load_i = 1'b0;
  logic                  break_load_i = 1'b0;
  logic [11:0]           periph_word_o;
  mrd_pkg::mrd_mem_req_s mem_o;
  logic                  mem_done_i;
  logic [11:0]           mem_rdata_i;
  logic [3:0]            time_state_o;
  logic                  time_pulse_o;
  logic [7:0]            opcode_level_o;
  logic [3:0]            mem_delay = 4'h0;
  logic [31:0]           seed = 32'h94ad;
  int                    errors = 0;
  int                    checks = 0;
  int                    cycles = 0;
  int                    m [5];
  int                    words [$];

  always #20 clock_i = ~clock_i;

  mrd_datapath i_mrd_datapath (
    .clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .switch_pins_i(sw), .address_load_key_i(keys[0]),
    .store_key_i(keys[1]), .inspect_key_i(keys[2]), .fetch_i(fetch_i), .add_i(add_i),
    .io_data_i(io_data_i), .io_load_i(io_load_i), .break_load_i(break_load_i),
    .periph_word_o(periph_word_o), .mem_o(mem_o), .mem_done_i(mem_done_i),
    .mem_rdata_i(mem_rdata_i), .time_state_o(time_state_o), .time_pulse_o(time_pulse_o),
    .opcode_level_o(opcode_level_o));

  mrd_mem_model i_mrd_mem_model (
    .clock_i(clock_i), .reset_i(reset_i), .mem_i(mem_o), .delay_i(mem_delay),
    .done_o(mem_done_i), .rdata_o(mem_rdata_i));

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  // transfer codes map to model slots: working, iptr, addr, buffer
  function automatic int dix(input int d);
    return (d == 0) ? 0 : d + 1;
  endfunction : dix

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [11:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic wait_cond(input int which);
    for (int k = 0; k < 200; k++) begin
      @(posedge clock_i);
      #1;
      if (which == 0 && mem_done_i === 1'b1) break;
      if (which == 1 && time_pulse_o === 1'b1 && time_state_o[3] === 1'b1) break;
    end
    repeat (2) @(posedge clock_i);
  endtask : wait_cond

  // keys are synced inside, so hold each level for several clocks
  task automatic press(input int k, input logic [11:0] v);
    sw <= v;
    repeat (4) @(posedge clock_i);
    keys[k] <= 1'b1;
    repeat (4) @(posedge clock_i);
    keys[k] <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : press

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    int          i;
    int          c;
    int          v;
    int          tab [7];
    logic [11:0] r;
    tab = '{8'h08, 8'h49, 8'h92, 8'h1d, 8'hc0, 8'h03, 8'h07};
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    wr(4'hf, 12'hfff);
    for (i = 0; i < 16; i++) begin
      if (i < 8 || i > 10) rd(4'(i), r);
      if (i < 8 || i > 10) chk("reset", 12'h000, r);
    end
    for (i = 0; i < 5; i++) begin
      m[i] = nxt() & 12'hfff;
      if (i == 1) m[i] = m[i] & 1;
      wr(4'(i), 12'((i == 1) ? (nxt() & 12'hffe | m[i]) : m[i]));
      rd(4'(i), r);
      chk("register", 12'(m[i]), r);
    end
    wr(4'h5, 12'hfff);
    rd(4'h5, r);
    chk("read word", 12'h000, r);
    sw <= 12'(nxt());
    for (i = 0; i < 7; i++) begin
      c = tab[i];
      v = ((c & 7) == 7) ? 0 : ((c & 7) == 5) ? int'(sw) : m[dix(c & 7)];
      if ((c >> 6) & 1) v = ~v;
      if ((c >> 7) & 1) v = v + 1;
      m[dix((c >> 3) & 7)] = v & 12'hfff;
      wr(4'h8, 12'(c));
      wait_cond(1);
      rd(4'(dix((c >> 3) & 7)), r);
      chk("transfer", 12'(m[dix((c >> 3) & 7)]), r);
    end
    chk("periph", 12'(m[4]), periph_word_o);
    wr(4'h0, 12'hfff);
    wr(4'h2, 12'h001);
    add_i <= 1'b1;
    wr(4'h8, 12'h001);
    wait_cond(1);
    add_i <= 1'b0;
    rd(4'h0, r);
    chk("sum", 12'h000, r);
    rd(4'h1, r);
    chk("carry", 12'(m[1] ^ 1), r);
    v = nxt() & 12'hfff;
    @(posedge clock_i);
    io_data_i <= 12'(v);
    io_load_i <= 1'b1;
    @(posedge clock_i);
    io_load_i <= 1'b0;
    rd(4'h0, r);
    chk("io word", 12'(v), r);
    io_data_i <= ~12'(v);
    break_load_i <= 1'b1;
    @(posedge clock_i);
    break_load_i <= 1'b0;
    rd(4'h4, r);
    chk("break word", ~12'(v), periph_word_o);
    press(0, 12'h100);
    rd(4'h3, r);
    chk("address key", 12'h100, r);
    for (i = 0; i < 8; i++) begin
      v = (i << 9) | (nxt() & 12'h1ff);
      words.push_back(v);
      mem_delay <= 4'(i);
      press(1, 12'(v));
      wait_cond(0);
      chk("stored", 12'(v), i_mrd_mem_model.core[12'h100 + i]);
      rd(4'h3, r);
      chk("next address", 12'(12'h101 + i), r);
    end
    press(0, 12'h100);
    press(2, 12'h000);
    wait_cond(0);
    rd(4'h5, r);
    chk("inspect", 12'(words[0]), r);
    rd(4'h3, r);
    chk("inspect address", 12'h101, r);
    for (i = 0; i < 8; i++) begin
      mem_delay <= 4'(7 - i);
      wr(4'h3, 12'(12'h100 + i));
      fetch_i <= 1'b1;
      wait_cond(0);
      while (time_state_o[3] !== 1'b1) @(posedge clock_i);
      fetch_i <= 1'b0;
      rd(4'h6, r);
      chk("opcode", 12'(i), r);
      chk("levels", 12'(8'h01 << i), {4'h0, opcode_level_o});
      rd(4'h5, r);
      chk("fetched", 12'(words[i]), r);
      rd(4'ha, r);
      chk("decode word", 12'(8'h01 << i), r);
    end
    complete_run();
  end
endmodule : mrd_datapath_tb

`default_nettype wire

// file: verification/mrd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module mrd_mem_model (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // request side
  input  wire mrd_pkg::mrd_mem_req_s mem_i,
  input  wire logic [3:0]            delay_i,
  // answer side
  output logic                       done_o,
  output logic [11:0]                rdata_o
);
  logic [11:0] core [4096];
  logic [3:0]  wait_cnt;
  logic        busy;

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o <= 12'h000;
    end else begin
      done_o <= 1'b0;
      // sense lines are not held outside done
      rdata_o <= ~rdata_o;
      if (mem_i.req && !busy && !done_o) begin
        busy <= 1'b1;
        wait_cnt <= delay_i;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        if (mem_i.write) core[mem_i.addr] <= mem_i.wdata;
        else rdata_o <= core[mem_i.addr];
      end
    end
  end
endmodule : mrd_mem_model

`default_nettype wire
